// File: mss_cfg.svh
`ifndef MSS_CFG_SVH
`define MSS_CFG_SVH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define MSS_OFS_CTRL 8'h00
`define MSS_OFS_PU_GAIN 8'h04
`define MSS_OFS_CT_RATIO 8'h08
`define MSS_OFS_VT_RATIO 8'h0C
`define MSS_OFS_CUTOFF 8'h10
`define MSS_OFS_REF_MIN 8'h14
`define MSS_OFS_E_AUTO_LIM 8'h18
`define MSS_OFS_DUR0 8'h1C
`define MSS_OFS_DUR1 8'h20
`define MSS_OFS_DUR2 8'h24
`define MSS_OFS_CMD 8'h28
`define MSS_OFS_STATUS 8'h2C
`define MSS_OFS_MIN 8'h30
`define MSS_OFS_MAX 8'h34
`define MSS_OFS_AVG0 8'h38
`define MSS_OFS_AVG1 8'h3C
`define MSS_OFS_AVG2 8'h40
`define MSS_OFS_PEAK0 8'h44
`define MSS_OFS_PEAK2 8'h48
`define MSS_OFS_ENERGY0 8'h4C
`define MSS_OFS_ENERGY1 8'h50
`define MSS_OFS_ENERGY2 8'h54

// ---------------------------------------------------------------------------
// Control and command register fields
// ---------------------------------------------------------------------------
`define MSS_CTRL_SCALE 1:0
`define MSS_CTRL_PUNIT 3:2
`define MSS_CTRL_EUNIT 5:4
`define MSS_CTRL_WIN0 6
`define MSS_CTRL_START0 9
`define MSS_CTRL_W 12
`define MSS_CMD_AVG_CLR 2:0
`define MSS_CMD_OVF_CLR 3

// ---------------------------------------------------------------------------
// Reset values and limits
// ---------------------------------------------------------------------------
`define MSS_CTRL_RST 12'h000
`define MSS_PU_GAIN_RST 16'h1000
`define MSS_RATIO_RST 16'h0001
`define MSS_CUTOFF_RST 16'h0000
`define MSS_REF_MIN_RST 16'h0010
`define MSS_E_AUTO_RST 32'h05F5_E0FF
`define MSS_DUR_RST 24'h000400
`define MSS_E_FIXED_MAX 32'h05F5_E0FF
`define MSS_PU_SHIFT 12
`define MSS_MEGA_FLOOR 32'h000F_4240
`define MSS_GIGA_FLOOR 32'h3B9A_CA00
`define MSS_DEC_FINE 3'h3
`define MSS_DEC_COARSE 3'h2
`define MSS_DEC_STEP 32'h0000_000A
`define MSS_MIN_RST 16'hFFFF
`define MSS_MAX_RST 16'h0000
`define MSS_RING_SHIFT 3
`define MSS_RING_N 8
`define MSS_REF_CH 9

`endif

// File: mss_pkg.sv
package mss_pkg;

  typedef enum logic [1:0] {
    SCALE_SECONDARY = 2'b00,
    SCALE_PRIMARY = 2'b01,
    SCALE_PER_UNIT = 2'b10
  } scale_e;

  typedef enum logic [1:0] {
    UNIT_AUTO = 2'b00,
    UNIT_KILO = 2'b01,
    UNIT_MEGA = 2'b10,
    UNIT_GIGA = 2'b11
  } unit_e;

endpackage : mss_pkg

// File: measurement_statistics_unit.sv
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mss_cfg.svh"

// Behaviour
// - Display value scaled secondary, primary or per-unit.
// - Auto power prefix from primaries, else fixed.
// - Energy prefix auto or fixed, all counters alike.
// - Energy counter restarts at zero past maximum.
// - Overflow indication whenever an energy counter wraps.
// - Display zero while magnitude below cutoff.
// - Recorded value bypasses the cutoff.
// - Angles taken from fundamental phasors only.
// - Reference is first healthy voltage channel.
// - Fallback to currents in card order.
// - Reference angle zero, others relative.
// - Min/max restart on clear, restart, reconfiguration.
// - Separate clear inputs for minimums and maximums.
// - Min/max cleared on rising edge only.
// - Three averaging channels, peaks on current, power.
// - Sliding window averages the most recent period.
// - Fixed window restarts accumulation each period.
// - Duration start times period by setting.
// - Signal start period between rising edges.
// - Direct command clears channel immediately.
// - Clear signal rising edge clears channel.
module measurement_statistics_unit (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Measurement front end
  input wire logic i_sample_valid,
  input wire logic [15:0] i_meas_value,
  input wire logic [2:0][15:0] i_energy_inc,
  input wire logic [2:0][15:0] i_demand_value,
  input wire logic i_voltage_transformer_connection,
  input wire logic [2:0][15:0] i_phase_voltage_mag,
  input wire logic [2:0][15:0] i_phase_voltage_ang,
  input wire logic [2:0][15:0] i_line_voltage_mag,
  input wire logic [2:0][15:0] i_line_voltage_ang,
  input wire logic [5:0][15:0] i_current_mag,
  input wire logic [5:0][15:0] i_current_ang,
  // Assignable signals
  input wire logic i_minimum_values_clear,
  input wire logic i_maximum_values_clear,
  input wire logic i_current_demand_start_signal,
  input wire logic i_voltage_average_start_signal,
  input wire logic i_power_demand_start_signal,
  input wire logic i_current_demand_clear,
  input wire logic i_voltage_average_clear,
  input wire logic i_power_demand_clear,
  // Results
  output logic [31:0] o_display_value,
  output logic [15:0] o_record_value,
  output logic [1:0] o_power_prefix,
  output logic [2:0] o_power_decimals,
  output logic [1:0] o_energy_prefix,
  output logic o_energy_overflow,
  output logic [3:0] o_ref_index,
  output logic [8:0][15:0] o_rel_angle
);

  // -------------------------------------------------------------------------
  // Register bus
  // -------------------------------------------------------------------------
  logic [`MSS_CTRL_W-1:0] ctrl_reg;
  logic [15:0] pu_gain_reg;
  logic [15:0] ct_ratio_reg;
  logic [15:0] vt_ratio_reg;
  logic [15:0] cutoff_reg;
  logic [15:0] ref_min_reg;
  logic [31:0] e_auto_lim_reg;
  logic [2:0][23:0] dur_reg;
  logic [2:0] ovf_sticky_reg;
  logic [15:0] min_reg;
  logic [15:0] max_reg;
  logic [2:0][15:0] avg_reg;
  logic [2:0][15:0] peak_reg;
  logic [2:0][31:0] energy_reg;
  logic wr_en;
  logic cfg_write;
  logic addr_ok;
  logic [2:0] cmd_avg_clr;
  logic cmd_ovf_clr;
  logic [31:0] rdata;

  assign wr_en = i_psel && i_penable && i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok;
  assign cmd_avg_clr = (wr_en && i_paddr == `MSS_OFS_CMD) ? i_pwdata[`MSS_CMD_AVG_CLR] : 3'h0;
  assign cmd_ovf_clr = wr_en && i_paddr == `MSS_OFS_CMD && i_pwdata[`MSS_CMD_OVF_CLR];
  // Any write to a setting register counts as a configuration change.
  assign cfg_write = wr_en && addr_ok && i_paddr <= `MSS_OFS_DUR2;

  always_comb begin
    addr_ok = 1'b1;
    rdata = 32'h0000_0000;
    unique case (i_paddr)
      `MSS_OFS_CTRL: rdata = {20'h00000, ctrl_reg};
      `MSS_OFS_PU_GAIN: rdata = {16'h0000, pu_gain_reg};
      `MSS_OFS_CT_RATIO: rdata = {16'h0000, ct_ratio_reg};
      `MSS_OFS_VT_RATIO: rdata = {16'h0000, vt_ratio_reg};
      `MSS_OFS_CUTOFF: rdata = {16'h0000, cutoff_reg};
      `MSS_OFS_REF_MIN: rdata = {16'h0000, ref_min_reg};
      `MSS_OFS_E_AUTO_LIM: rdata = e_auto_lim_reg;
      `MSS_OFS_DUR0: rdata = {8'h00, dur_reg[0]};
      `MSS_OFS_DUR1: rdata = {8'h00, dur_reg[1]};
      `MSS_OFS_DUR2: rdata = {8'h00, dur_reg[2]};
      `MSS_OFS_CMD: rdata = 32'h0000_0000;
      `MSS_OFS_STATUS: rdata = {21'h000000, o_ref_index, o_energy_prefix, ovf_sticky_reg};
      `MSS_OFS_MIN: rdata = {16'h0000, min_reg};
      `MSS_OFS_MAX: rdata = {16'h0000, max_reg};
      `MSS_OFS_AVG0: rdata = {16'h0000, avg_reg[0]};
      `MSS_OFS_AVG1: rdata = {16'h0000, avg_reg[1]};
      `MSS_OFS_AVG2: rdata = {16'h0000, avg_reg[2]};
      `MSS_OFS_PEAK0: rdata = {16'h0000, peak_reg[0]};
      `MSS_OFS_PEAK2: rdata = {16'h0000, peak_reg[2]};
      `MSS_OFS_ENERGY0: rdata = energy_reg[0];
      `MSS_OFS_ENERGY1: rdata = energy_reg[1];
      `MSS_OFS_ENERGY2: rdata = energy_reg[2];
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= rdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      ctrl_reg <= `MSS_CTRL_RST;
      pu_gain_reg <= `MSS_PU_GAIN_RST;
      ct_ratio_reg <= `MSS_RATIO_RST;
      vt_ratio_reg <= `MSS_RATIO_RST;
      cutoff_reg <= `MSS_CUTOFF_RST;
      ref_min_reg <= `MSS_REF_MIN_RST;
      e_auto_lim_reg <= `MSS_E_AUTO_RST;
      dur_reg <= {3{`MSS_DUR_RST}};
    end else if (wr_en) begin
      unique case (i_paddr)
        `MSS_OFS_CTRL: ctrl_reg <= i_pwdata[`MSS_CTRL_W-1:0];
        `MSS_OFS_PU_GAIN: pu_gain_reg <= i_pwdata[15:0];
        `MSS_OFS_CT_RATIO: ct_ratio_reg <= i_pwdata[15:0];
        `MSS_OFS_VT_RATIO: vt_ratio_reg <= i_pwdata[15:0];
        `MSS_OFS_CUTOFF: cutoff_reg <= i_pwdata[15:0];
        `MSS_OFS_REF_MIN: ref_min_reg <= i_pwdata[15:0];
        `MSS_OFS_E_AUTO_LIM: e_auto_lim_reg <= i_pwdata;
        `MSS_OFS_DUR0: dur_reg[0] <= i_pwdata[23:0];
        `MSS_OFS_DUR1: dur_reg[1] <= i_pwdata[23:0];
        `MSS_OFS_DUR2: dur_reg[2] <= i_pwdata[23:0];
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Edge detection
  // -------------------------------------------------------------------------
  logic [7:0] edge_in;
  logic [7:0] edge_prev_reg;
  logic [7:0] rise;

  assign edge_in = {i_power_demand_clear, i_voltage_average_clear, i_current_demand_clear,
                    i_power_demand_start_signal, i_voltage_average_start_signal,
                    i_current_demand_start_signal, i_maximum_values_clear,
                    i_minimum_values_clear};
  // The previous level resets high so that a line already high at reset is no edge.
  assign rise = edge_in & ~edge_prev_reg;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      edge_prev_reg <= 8'hFF;
    end else begin
      edge_prev_reg <= edge_in;
    end
  end

  // -------------------------------------------------------------------------
  // Display scaling and cutoff
  // -------------------------------------------------------------------------
  logic [31:0] scaled;
  logic [31:0] pu_product;
  mss_pkg::scale_e scale_sel;

  assign scale_sel = mss_pkg::scale_e'(ctrl_reg[`MSS_CTRL_SCALE]);
  assign pu_product = i_meas_value * pu_gain_reg;

  always_comb begin
    unique case (scale_sel)
      mss_pkg::SCALE_PRIMARY: scaled = i_meas_value * ct_ratio_reg;
      mss_pkg::SCALE_PER_UNIT: scaled = pu_product >> `MSS_PU_SHIFT;
      default: scaled = {16'h0000, i_meas_value};
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_display_value <= 32'h0000_0000;
      o_record_value <= 16'h0000;
    end else if (i_sample_valid) begin
      o_display_value <= (i_meas_value < cutoff_reg) ? 32'h0000_0000 : scaled;
      o_record_value <= i_meas_value;
    end
  end

  // -------------------------------------------------------------------------
  // Power and energy units
  // -------------------------------------------------------------------------
  logic [31:0] rated;
  logic [1:0] auto_prefix;
  logic [31:0] prefix_floor;
  mss_pkg::unit_e p_unit;
  mss_pkg::unit_e e_unit;

  assign rated = ct_ratio_reg * vt_ratio_reg;
  assign p_unit = mss_pkg::unit_e'(ctrl_reg[`MSS_CTRL_PUNIT]);
  assign e_unit = mss_pkg::unit_e'(ctrl_reg[`MSS_CTRL_EUNIT]);

  always_comb begin
    if (rated >= `MSS_GIGA_FLOOR) begin
      auto_prefix = mss_pkg::UNIT_GIGA;
      prefix_floor = `MSS_GIGA_FLOOR;
    end else if (rated >= `MSS_MEGA_FLOOR) begin
      auto_prefix = mss_pkg::UNIT_MEGA;
      prefix_floor = `MSS_MEGA_FLOOR;
    end else begin
      auto_prefix = mss_pkg::UNIT_KILO;
      prefix_floor = 32'h0000_0001;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_power_prefix <= mss_pkg::UNIT_KILO;
      o_power_decimals <= `MSS_DEC_COARSE;
      o_energy_prefix <= mss_pkg::UNIT_KILO;
    end else begin
      // With the auto power prefix, small ratings within a prefix step get one more decimal place.
      if (p_unit == mss_pkg::UNIT_AUTO) begin
        o_power_prefix <= auto_prefix;
        o_power_decimals <= (rated < prefix_floor * `MSS_DEC_STEP) ?
                            `MSS_DEC_FINE : `MSS_DEC_COARSE;
      end else begin
        o_power_prefix <= p_unit;
        o_power_decimals <= `MSS_DEC_COARSE;
      end
      o_energy_prefix <= (e_unit == mss_pkg::UNIT_AUTO) ? auto_prefix : e_unit;
    end
  end

  // Counters hold hundredths of the selected prefix unit.
  logic [31:0] e_limit;
  logic [2:0] e_wrap;
  logic [2:0][32:0] e_sum;

  assign e_limit = (e_unit == mss_pkg::UNIT_AUTO) ? e_auto_lim_reg : `MSS_E_FIXED_MAX;

  genvar e;
  generate
    for (e = 0; e < 3; e++) begin : g_energy
      assign e_sum[e] = {1'b0, energy_reg[e]} + {17'h00000, i_energy_inc[e]};
      assign e_wrap[e] = i_sample_valid && e_sum[e] > {1'b0, e_limit};
      always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
          energy_reg[e] <= 32'h0000_0000;
        end else if (e_wrap[e]) begin
          energy_reg[e] <= 32'h0000_0000;
        end else if (i_sample_valid) begin
          energy_reg[e] <= e_sum[e][31:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_energy_overflow <= 1'b0;
      ovf_sticky_reg <= 3'h0;
    end else begin
      o_energy_overflow <= |e_wrap;
      // A wrap in the same cycle as the clear command still sets its bit.
      ovf_sticky_reg <= (cmd_ovf_clr ? 3'h0 : ovf_sticky_reg) | e_wrap;
    end
  end

  // -------------------------------------------------------------------------
  // Reference phasor and relative angles
  // -------------------------------------------------------------------------
  logic [8:0][15:0] ref_mag;
  logic [8:0][15:0] ref_ang;
  logic [3:0] ref_pick;
  logic ref_found;

  // Inputs are fundamental-frequency phasors; harmonics never reach here.
  assign ref_mag = {i_current_mag, i_voltage_transformer_connection ?
                    i_line_voltage_mag : i_phase_voltage_mag};
  assign ref_ang = {i_current_ang, i_voltage_transformer_connection ?
                    i_line_voltage_ang : i_phase_voltage_ang};

  always_comb begin
    ref_pick = 4'h0;
    ref_found = 1'b0;
    // Voltages come first, then currents of card one and card two.
    for (int k = 0; k < `MSS_REF_CH; k++) begin
      if (!ref_found && ref_mag[k] >= ref_min_reg) begin
        ref_pick = 4'(k);
        ref_found = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_ref_index <= 4'h0;
      o_rel_angle <= '0;
    end else if (i_sample_valid) begin
      // With no healthy channel the last reference is kept.
      if (ref_found) begin
        o_ref_index <= ref_pick;
      end
      for (int k = 0; k < `MSS_REF_CH; k++) begin
        o_rel_angle[k] <= ref_ang[k] - ref_ang[ref_found ? ref_pick : o_ref_index];
      end
    end
  end

  // -------------------------------------------------------------------------
  // Minimum and maximum tracking
  // -------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn || rise[0] || cfg_write) begin
      min_reg <= `MSS_MIN_RST;
    end else if (i_sample_valid && i_meas_value < min_reg) begin
      min_reg <= i_meas_value;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn || rise[1] || cfg_write) begin
      max_reg <= `MSS_MAX_RST;
    end else if (i_sample_valid && i_meas_value > max_reg) begin
      max_reg <= i_meas_value;
    end
  end

  // -------------------------------------------------------------------------
  // Demand averaging channels
  // -------------------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_avg
      logic [39:0] acc_reg;
      logic [23:0] cnt_reg;
      logic [23:0] timer_reg;
      logic [15:0] ring_reg [`MSS_RING_N];
      logic [2:0] ptr_reg;
      logic [3:0] fill_reg;
      logic [18:0] ring_sum_reg;
      logic sliding;
      logic by_edge;
      logic clr;
      logic [23:0] slot_len;
      logic slot_end;
      logic [39:0] acc_n;
      logic [23:0] cnt_n;
      logic [15:0] slot_avg;
      logic [18:0] sum_n;
      logic [3:0] fill_n;
      logic [15:0] avg_n;

      assign sliding = !ctrl_reg[`MSS_CTRL_WIN0 + c];
      assign by_edge = ctrl_reg[`MSS_CTRL_START0 + c];
      assign clr = cmd_avg_clr[c] || rise[5 + c];
      // A sliding window is kept as the last eight sub-periods of the length.
      assign slot_len = sliding ? (dur_reg[c] >> `MSS_RING_SHIFT) : dur_reg[c];
      assign slot_end = by_edge ? rise[2 + c] :
                        (i_sample_valid && timer_reg + 24'h000001 >= slot_len);
      assign acc_n = acc_reg + (i_sample_valid ? {24'h000000, i_demand_value[c]} : 40'h0);
      assign cnt_n = cnt_reg + (i_sample_valid ? 24'h000001 : 24'h000000);
      assign slot_avg = (cnt_n == 24'h000000) ? 16'h0000 : 16'(acc_n / {16'h0000, cnt_n});
      assign sum_n = ring_sum_reg - {3'h0, ring_reg[ptr_reg]} + {3'h0, slot_avg};
      assign fill_n = (fill_reg == 4'(`MSS_RING_N)) ? fill_reg : fill_reg + 4'h1;
      assign avg_n = sliding ? 16'(sum_n / {15'h0000, fill_n}) : slot_avg;

      always_ff @(posedge i_sys_clk) begin
        if (!i_rstn || clr) begin
          acc_reg <= 40'h0;
          cnt_reg <= 24'h000000;
          timer_reg <= 24'h000000;
        end else if (slot_end) begin
          acc_reg <= 40'h0;
          cnt_reg <= 24'h000000;
          timer_reg <= 24'h000000;
        end else begin
          acc_reg <= acc_n;
          cnt_reg <= cnt_n;
          timer_reg <= timer_reg + (i_sample_valid ? 24'h000001 : 24'h000000);
        end
      end

      always_ff @(posedge i_sys_clk) begin
        if (!i_rstn || clr) begin
          ptr_reg <= 3'h0;
          fill_reg <= 4'h0;
          ring_sum_reg <= 19'h00000;
          for (int k = 0; k < `MSS_RING_N; k++) begin
            ring_reg[k] <= 16'h0000;
          end
        end else if (slot_end && sliding) begin
          ring_reg[ptr_reg] <= slot_avg;
          ring_sum_reg <= sum_n;
          ptr_reg <= ptr_reg + 3'h1;
          fill_reg <= fill_n;
        end
      end

      always_ff @(posedge i_sys_clk) begin
        if (!i_rstn || clr) begin
          avg_reg[c] <= 16'h0000;
          peak_reg[c] <= 16'h0000;
        end else if (slot_end) begin
          avg_reg[c] <= avg_n;
          // The voltage channel keeps no peak.
          if (c != 1 && avg_n > peak_reg[c]) begin
            peak_reg[c] <= avg_n;
          end
        end
      end
    end
  endgenerate

endmodule : measurement_statistics_unit

`default_nettype wire

// File: front_end_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// Measurement front end strobe
// ----------
module front_end_model (
  // Clock
  input wire logic i_sys_clk,
  // Sample strobe
  output logic o_sample_valid
);
  initial o_sample_valid = 1'b0;
  // Strobes are four clocks apart so every sampled output settles first.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      o_sample_valid <= 1'b1;
      @(posedge i_sys_clk);
      o_sample_valid <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
    end
  endtask : pulse
endmodule : front_end_model
`default_nettype wire

// File: measurement_statistics_unit_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// Port checker
// ----------
module mss_checker (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Watched ports
  input wire logic i_sample_valid,
  input wire logic [31:0] o_display_value,
  input wire logic [15:0] o_record_value,
  input wire logic [1:0] o_power_prefix,
  input wire logic [2:0] o_power_decimals,
  input wire logic [1:0] o_energy_prefix,
  input wire logic o_energy_overflow,
  input wire logic [3:0] o_ref_index,
  input wire logic [8:0][15:0] o_rel_angle
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  property p_disp;
    $changed(o_display_value) |-> $past(i_sample_valid);
  endproperty
  a_disp: assert property (p_disp) else $error("display moved");
  property p_rec;
    $changed(o_record_value) |-> $past(i_sample_valid);
  endproperty
  a_rec: assert property (p_rec) else $error("record moved");
  property p_ovf;
    o_energy_overflow |-> $past(i_sample_valid) ##1 !o_energy_overflow;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow pulse bad");
  property p_ref_rng;
    o_ref_index <= 4'h8;
  endproperty
  a_ref_rng: assert property (p_ref_rng) else $error("reference index bad");
  property p_ref_zero;
    $past(i_sample_valid) |-> o_rel_angle[o_ref_index] == 16'h0;
  endproperty
  a_ref_zero: assert property (p_ref_zero) else $error("reference angle bad");
  property p_ppre;
    o_power_prefix != 2'h0;
  endproperty
  a_ppre: assert property (p_ppre) else $error("power prefix bad");
  property p_pdec;
    o_power_decimals == 3'h2 || o_power_decimals == 3'h3;
  endproperty
  a_pdec: assert property (p_pdec) else $error("decimals bad");
  property p_epre;
    o_energy_prefix != 2'h0;
  endproperty
  a_epre: assert property (p_epre) else $error("energy prefix bad");
endmodule : mss_checker
bind measurement_statistics_unit mss_checker mss_checker_i (.i_sys_clk, .i_rstn,
  .i_sample_valid, .o_display_value, .o_record_value, .o_power_prefix,
  .o_power_decimals, .o_energy_prefix, .o_energy_overflow, .o_ref_index, .o_rel_angle);
`default_nettype wire

// File: measurement_statistics_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %0h got %0h", n, e, a); end end
// ----------
// Bench
// ----------
module measurement_statistics_unit_bench;
  logic i_sys_clk = '0, i_rstn = '0, i_psel = '0, i_penable = '0, i_pwrite = '0;
  logic [7:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, o_prdata, o_display_value;
  logic o_pready, o_pslverr, i_sample_valid, last_err;
  logic i_voltage_transformer_connection = '0;
  logic [15:0] i_meas_value = '0, o_record_value;
  logic [2:0][15:0] i_energy_inc = '0, i_demand_value = '0, i_phase_voltage_mag = '0;
  logic [2:0][15:0] i_phase_voltage_ang = '0, i_line_voltage_mag = '0, i_line_voltage_ang = '0;
  logic [5:0][15:0] i_current_mag = '0, i_current_ang = '0;
  logic i_minimum_values_clear = '0, i_maximum_values_clear = '0;
  logic i_current_demand_start_signal = '0, i_voltage_average_start_signal = '0;
  logic i_power_demand_start_signal = '0, i_current_demand_clear = '0;
  logic i_voltage_average_clear = '0, i_power_demand_clear = '0;
  logic [1:0] o_power_prefix, o_energy_prefix;
  logic [2:0] o_power_decimals;
  logic o_energy_overflow;
  logic [3:0] o_ref_index;
  logic [8:0][15:0] o_rel_angle;
  int fail_count = 0, n_tests = 0, ovf_seen = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (o_energy_overflow === 1'b1) ovf_seen++;
  measurement_statistics_unit measurement_statistics_unit_i (.*);
  front_end_model front_end_model_i (.i_sys_clk, .o_sample_valid(i_sample_valid));
  task automatic final_report;
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // ----------
  // Bus and sample helpers
  // ----------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int k = 0;
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail_count++;
      final_report();
    end
    r = o_prdata;
    last_err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    `CHK("prdata", x, r)
  endtask : rd
  task automatic smp(input int n);
    front_end_model_i.pulse(n);
  endtask : smp
  // ----------
  // Scenarios
  // ----------
  task automatic t_reset;
    logic [31:0] r;
    `CHK("power_prefix", 2'h1, o_power_prefix)
    `CHK("energy_prefix", 2'h1, o_energy_prefix)
    rd(8'h30, 32'hFFFF);
    rd(8'h34, 32'h0);
    apb(1'b0, 8'h58, 32'h0, r);
    `CHK("pslverr", 1'b1, last_err)
  endtask : t_reset
  task automatic t_scale;
    logic [31:0] ex [3] = '{32'h64, 32'h1F4, 32'hC8};
    wr(8'h08, 32'h5);
    wr(8'h0C, 32'h5);
    wr(8'h04, 32'h2000);
    i_meas_value <= 16'h64;
    for (int s = 0; s < 3; s++) begin
      wr(8'h00, 32'(s));
      smp(1);
      `CHK("display", ex[s], o_display_value)
    end
    wr(8'h10, 32'hC8);
    wr(8'h00, 32'h0);
    smp(1);
    `CHK("display", 32'h0, o_display_value)
    `CHK("record", 16'h64, o_record_value)
    wr(8'h10, 32'h0);
  endtask : t_scale
  task automatic t_power;
    for (int u = 1; u < 4; u++) begin
      wr(8'h00, 32'(u * 20));
      smp(1);
      `CHK("power_prefix", 2'(u), o_power_prefix)
      `CHK("energy_prefix", 2'(u), o_energy_prefix)
    end
    wr(8'h08, 32'h3E8);
    wr(8'h0C, 32'h3E8);
    wr(8'h00, 32'h0);
    smp(1);
    `CHK("power_prefix", 2'h2, o_power_prefix)
    `CHK("decimals", 3'h3, o_power_decimals)
  endtask : t_power
  task automatic t_ref;
    i_phase_voltage_mag <= {16'h64, 16'h64, 16'h0};
    i_phase_voltage_ang[1] <= 16'h1000;
    i_current_mag <= {6{16'h64}};
    i_current_ang[0] <= 16'h3000;
    smp(1);
    `CHK("ref", 4'h1, o_ref_index)
    `CHK("angle", 16'h0, o_rel_angle[1])
    `CHK("angle", 16'h2000, o_rel_angle[3])
    i_phase_voltage_mag <= '0;
    i_current_mag <= {16'h64, 16'h64, 16'h64, 16'h0, 16'h0, 16'h0};
    i_current_ang[3] <= 16'h1000;
    smp(1);
    `CHK("ref", 4'h6, o_ref_index)
    `CHK("angle", 16'h2000, o_rel_angle[3])
    i_voltage_transformer_connection <= 1'b1;
    i_line_voltage_mag[0] <= 16'h64;
    smp(1);
    `CHK("ref", 4'h0, o_ref_index)
    `CHK("angle", 16'h3000, o_rel_angle[3])
  endtask : t_ref
  task automatic t_minmax;
    logic [15:0] v [3] = '{16'h64, 16'h32, 16'h12C};
    wr(8'h00, 32'h0);
    foreach (v[i]) begin
      i_meas_value <= v[i];
      smp(1);
    end
    rd(8'h30, 32'h32);
    rd(8'h34, 32'h12C);
    i_maximum_values_clear <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    rd(8'h34, 32'h0);
    rd(8'h30, 32'h32);
    i_meas_value <= 16'h46;
    i_minimum_values_clear <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    rd(8'h30, 32'hFFFF);
    smp(1);
    rd(8'h34, 32'h46);
    rd(8'h30, 32'h46);
    wr(8'h00, 32'h0);
    rd(8'h30, 32'hFFFF);
    rd(8'h34, 32'h0);
  endtask : t_minmax
  task automatic t_avg;
    wr(8'h1C, 32'h4);
    wr(8'h20, 32'h8);
    wr(8'h00, 32'h40);
    wr(8'h28, 32'h3);
    i_demand_value <= {16'h0, 16'h10, 16'h8};
    smp(4);
    rd(8'h38, 32'h8);
    rd(8'h44, 32'h8);
    i_demand_value[0] <= 16'h4;
    smp(4);
    rd(8'h38, 32'h4);
    rd(8'h44, 32'h8);
    rd(8'h3C, 32'h10);
    i_demand_value[1] <= 16'h0;
    smp(4);
    rd(8'h3C, 32'h8);
    wr(8'h28, 32'h1);
    rd(8'h38, 32'h0);
    rd(8'h44, 32'h0);
  endtask : t_avg
  task automatic t_edge;
    wr(8'h00, 32'h940);
    wr(8'h28, 32'h4);
    i_demand_value[2] <= 16'h6;
    smp(3);
    i_power_demand_start_signal <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    rd(8'h40, 32'h6);
    rd(8'h48, 32'h6);
    i_demand_value[2] <= 16'hC;
    smp(2);
    rd(8'h40, 32'h6);
    i_power_demand_start_signal <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_power_demand_start_signal <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    rd(8'h40, 32'hC);
    rd(8'h48, 32'hC);
    {i_power_demand_clear, i_voltage_average_clear, i_current_demand_clear} <= 3'h7;
    repeat (3) @(posedge i_sys_clk);
    rd(8'h40, 32'h0);
    rd(8'h48, 32'h0);
    rd(8'h3C, 32'h0);
  endtask : t_edge
  task automatic t_energy;
    wr(8'h00, 32'h10);
    i_energy_inc[0] <= 16'hFFFF;
    smp(1525);
    rd(8'h4C, 32'h05F4FA0B);
    `CHK("overflow", 0, ovf_seen)
    smp(1);
    i_energy_inc[0] <= 16'h0;
    rd(8'h4C, 32'h0);
    `CHK("overflow", 1, ovf_seen)
    rd(8'h2C, 32'h9);
    wr(8'h28, 32'h8);
    rd(8'h2C, 32'h8);
  endtask : t_energy
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    @(posedge i_sys_clk);
    t_reset();
    t_scale();
    t_power();
    t_ref();
    t_minmax();
    t_avg();
    t_edge();
    t_energy();
    final_report();
  end
  initial begin
    #400000;
    fail_count++;
    final_report();
  end
endmodule : measurement_statistics_unit_bench
`default_nettype wire
